/* File: core/rtc_pkg.sv */
package rtc_pkg;
    // register offsets on the internal register port
    localparam logic [7:0] ADDR_SEC   = 8'h10;
    localparam logic [7:0] ADDR_ASEC  = 8'h11;
    localparam logic [7:0] ADDR_MIN   = 8'h12;
    localparam logic [7:0] ADDR_AMIN  = 8'h13;
    localparam logic [7:0] ADDR_HR    = 8'h14;
    localparam logic [7:0] ADDR_AHR   = 8'h15;
    localparam logic [7:0] ADDR_WDAY  = 8'h16;
    localparam logic [7:0] ADDR_MDAY  = 8'h17;
    localparam logic [7:0] ADDR_MON   = 8'h18;
    localparam logic [7:0] ADDR_YEAR  = 8'h19;
    localparam logic [7:0] ADDR_STAT  = 8'h1A;
    localparam logic [7:0] ADDR_CTRL  = 8'h1B;
    localparam logic [7:0] ADDR_FLAG  = 8'h1C;
    // reset values and writable masks
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] RST_ONE    = 8'h01;
    localparam logic [7:0] RST_STAT   = 8'h20;
    localparam logic [7:0] RST_CTRL   = 8'h02;
    localparam logic [7:0] MSK_CTRL   = 8'hB6;
    localparam logic [7:0] MSK_SM     = 8'h7F;
    localparam logic [7:0] MSK_HR     = 8'hBF;
    // field positions
    localparam int B_HR24       = 1;
    localparam int B_BIN        = 2;
    localparam int B_UPD_IRQ_EN = 4;
    localparam int B_ALM_IRQ_EN = 5;
    localparam int B_SET        = 7;
    localparam int B_PM         = 7;
    localparam int B_UPD_FLAG   = 4;
    localparam int B_ALM_FLAG   = 5;
    localparam int B_TOP        = 7;
    // calendar limits, binary
    localparam logic [7:0] LIM_SM   = 8'h3B;
    localparam logic [7:0] LIM_H24  = 8'h17;
    localparam logic [7:0] LIM_H12  = 8'h0C;
    localparam logic [7:0] PRE_NOON = 8'h0B;
    localparam logic [7:0] LIM_WDAY = 8'h07;
    localparam logic [7:0] LIM_MON  = 8'h0C;
    localparam logic [7:0] LIM_YEAR = 8'h63;
    localparam logic [7:0] TEN      = 8'h0A;
    // month codes with short months, and days per month, binary
    localparam logic [7:0] MON_FEB   = 8'h02;
    localparam logic [7:0] MON_APR   = 8'h04;
    localparam logic [7:0] MON_JUN   = 8'h06;
    localparam logic [7:0] MON_SEP   = 8'h09;
    localparam logic [7:0] MON_NOV   = 8'h0B;
    localparam logic [7:0] DIM_FEB   = 8'h1C;
    localparam logic [7:0] DIM_LEAP  = 8'h1D;
    localparam logic [7:0] DIM_SHORT = 8'h1E;
    localparam logic [7:0] DIM_LONG  = 8'h1F;
    // timing
    localparam real CLK_MHZ      = 50.0;
    localparam real SLACK        = 0.001;
    localparam real SEC_S        = 1.0;
    localparam real PEND_LEAD_US = 244.1;
    localparam real UPD_US       = 30.5;
    localparam int  SEC_CYC  = int'(SEC_S * CLK_MHZ * 1.0e6);
    localparam int  LEAD_CYC = int'($ceil(PEND_LEAD_US * CLK_MHZ - SLACK));
    localparam int  UPD_CYC  = int'($ceil(UPD_US * CLK_MHZ - SLACK));
    // one register access, write or read
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

/* File: core/rtc_time_calendar_regs.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - hour format bit: 0 is 12-hour, 1 is 24-hour; hours bit 7 is PM.
// - hours alarm bit 7 holds alarm PM, compared only in 12-hour format.
// - seconds/minutes alarms use bits 6:0, hours alarm bits 5:0.
// - weekday in bits 2:0, 1 Sunday to 7 Saturday, resets to 1.
// - day of month bits 5:0, month bits 4:0, both reset to 1.
// - month bit 7 is unsupported and always reads zero.
// - year uses bits 7:0, counts 0 to 99, resets to zero.
// - status bit 7 reads 1 while an update is pending or running.
// - control bit 2 selects BCD (0) or binary (1) counting.
// - control bit 4 lets the update-done flag raise the request.
// - control bit 5 lets the alarm flag raise the request.
// - control bit 7 aborts a running update and starts none.
// - with control bit 7 clear, counters advance once per second.
// - request flag equals alarm AND enable OR update-done AND enable.
// - alarm flag sets at update end only if all three fields match.
// - reading the flag register clears set flags; new events survive.
// - pending bit rises 244.1 us before increment, clears after compare.
module rtc_time_calendar_regs #(
    parameter int SEC_CYC  = rtc_pkg::SEC_CYC,
    parameter int LEAD_CYC = rtc_pkg::LEAD_CYC
) (
    // clock and reset
    input  logic              clk_i,
    input  logic              rst_n_i,
    // register port
    input  rtc_pkg::reg_req_t req_i,
    output logic [7:0]        rdata_o,
    // request level, same as flag bit 7
    output logic              irq_o
);
    import rtc_pkg::*;

    typedef enum logic [1:0] {ST_RUN, ST_PEND, ST_UPD} phase_t;

    // the lead must outlast the eight-cycle lead check; lead plus update fit in one second
    if (LEAD_CYC < 9 || UPD_CYC < 1 || LEAD_CYC + UPD_CYC >= SEC_CYC) begin : g_chk
        $error("second too short for lead and update window");
    end

    logic       rst_meta_reg;
    logic       rst_sync_n;
    phase_t     phase_reg;
    logic [31:0] sec_cnt_reg;
    logic [31:0] upd_cnt_reg;
    logic [6:0] sec_reg, asec_reg, min_reg, amin_reg;
    logic [7:0] hr_reg, ahr_reg, year_reg, ctrl_reg;
    logic [2:0] wday_reg;
    logic [5:0] mday_reg;
    logic [4:0] mon_reg;
    logic       alarm_flag_reg, update_done_flag_reg;
    logic       bcd, hr24, set_mode, inc_pulse, upd_end, flg_rd;
    logic       alarm_s_match, alarm_m_match, alarm_h_match, all_match;
    logic       rtc_irq_request, update_pending_flag;
    logic [7:0] rd_mux;
    logic [7:0] s_b, m_b, h_b, d_b, mo_b, y_b, dim;
    logic       c_min, c_hr, c_day, c_mon, c_yr;
    logic [7:0] sec_nx, min_nx, hr_nx, mday_nx, mon_nx, year_nx;
    logic [2:0] wday_nx;

    // reset: asserted at once, released through two flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_n   <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_n   <= rst_meta_reg;
        end
    end

    function automatic logic [7:0] to_bin(input logic [7:0] v, input logic is_bcd);
        return is_bcd ? 8'({4'h0, v[7:4]} * TEN + {4'h0, v[3:0]}) : v;
    endfunction

    function automatic logic [7:0] to_fmt(input logic [7:0] b, input logic is_bcd);
        return is_bcd ? {4'(b / TEN), 4'(b % TEN)} : b;
    endfunction

    // control decode
    assign bcd       = ~ctrl_reg[B_BIN];
    assign hr24      = ctrl_reg[B_HR24];
    assign set_mode  = ctrl_reg[B_SET];
    assign inc_pulse = (phase_reg == ST_PEND) && (sec_cnt_reg == 32'(SEC_CYC - 1));
    // set mode aborts a closing update too, so the aborted update raises no flag
    assign upd_end   = (phase_reg == ST_UPD) && (upd_cnt_reg == 32'(UPD_CYC - 1)) && !set_mode;
    assign flg_rd    = req_i.rd && (req_i.addr == ADDR_FLAG);
    assign update_pending_flag = (phase_reg != ST_RUN);

    // alarm compare; pm bit only counts in 12-hour format
    assign alarm_s_match = (sec_reg == asec_reg);
    assign alarm_m_match = (min_reg == amin_reg);
    assign alarm_h_match = hr24 ? (hr_reg[5:0] == ahr_reg[5:0])
                                : (hr_reg == ahr_reg);
    assign all_match     = alarm_s_match && alarm_m_match && alarm_h_match;

    // request flag is a pure function of flags and enables
    assign rtc_irq_request = (alarm_flag_reg & ctrl_reg[B_ALM_IRQ_EN])
                           | (update_done_flag_reg & ctrl_reg[B_UPD_IRQ_EN]);
    assign irq_o = rtc_irq_request;

    // one-second rollover, worked in binary then returned to the chosen format
    always_comb begin
        s_b  = to_bin({1'b0, sec_reg}, bcd);
        m_b  = to_bin({1'b0, min_reg}, bcd);
        h_b  = to_bin({2'b00, hr_reg[5:0]}, bcd);
        d_b  = to_bin({2'b00, mday_reg}, bcd);
        mo_b = to_bin({3'b000, mon_reg}, bcd);
        y_b  = to_bin(year_reg, bcd);
        case (mo_b)
            MON_FEB: dim = (y_b[1:0] == 2'b00) ? DIM_LEAP : DIM_FEB;
            MON_APR, MON_JUN, MON_SEP, MON_NOV: dim = DIM_SHORT;
            default: dim = DIM_LONG;
        endcase
        c_min  = (s_b >= LIM_SM);
        c_hr   = c_min && (m_b >= LIM_SM);
        sec_nx = to_fmt(c_min ? RST_ZERO : 8'(s_b + 8'h01), bcd);
        min_nx = c_min ? to_fmt(c_hr ? RST_ZERO : 8'(m_b + 8'h01), bcd)
                       : {1'b0, min_reg};
        hr_nx  = hr_reg;
        c_day  = 1'b0;
        if (c_hr && hr24) begin
            c_day = (h_b >= LIM_H24);
            hr_nx = to_fmt(c_day ? RST_ZERO : 8'(h_b + 8'h01), bcd);
        end else if (c_hr) begin
            // 11 to 12 flips am/pm; pm 11 to am 12 starts a new day
            c_day = (h_b == PRE_NOON) && hr_reg[B_PM];
            hr_nx = to_fmt((h_b >= LIM_H12) ? RST_ONE : 8'(h_b + 8'h01), bcd);
            hr_nx[B_PM] = hr_reg[B_PM] ^ (h_b == PRE_NOON);
        end
        c_mon  = c_day && (d_b >= dim);
        c_yr   = c_mon && (mo_b >= LIM_MON);
        wday_nx = !c_day ? wday_reg
                : (wday_reg >= LIM_WDAY[2:0]) ? RST_ONE[2:0] : 3'(wday_reg + 3'd1);
        mday_nx = !c_day ? {2'b00, mday_reg}
               : to_fmt(c_mon ? RST_ONE : 8'(d_b + 8'h01), bcd);
        mon_nx = !c_mon ? {3'b000, mon_reg}
               : to_fmt(c_yr ? RST_ONE : 8'(mo_b + 8'h01), bcd);
        year_nx = !c_yr ? year_reg
                : to_fmt((y_b >= LIM_YEAR) ? RST_ZERO : 8'(y_b + 8'h01), bcd);
    end

    // read mux; reserved bits come back as zero
    assign rd_mux =
        (req_i.addr == ADDR_SEC)  ? {1'b0, sec_reg}  :
        (req_i.addr == ADDR_ASEC) ? {1'b0, asec_reg} :
        (req_i.addr == ADDR_MIN)  ? {1'b0, min_reg}  :
        (req_i.addr == ADDR_AMIN) ? {1'b0, amin_reg} :
        (req_i.addr == ADDR_HR)   ? hr_reg           :
        (req_i.addr == ADDR_AHR)  ? ahr_reg          :
        (req_i.addr == ADDR_WDAY) ? {5'b00000, wday_reg} :
        (req_i.addr == ADDR_MDAY) ? {2'b00, mday_reg} :
        (req_i.addr == ADDR_MON)  ? {3'b000, mon_reg} :
        (req_i.addr == ADDR_YEAR) ? year_reg         :
        (req_i.addr == ADDR_STAT) ? (RST_STAT | {update_pending_flag, 7'h00}) :
        (req_i.addr == ADDR_CTRL) ? ctrl_reg         :
        (req_i.addr == ADDR_FLAG) ? {rtc_irq_request, 1'b0, alarm_flag_reg,
                                     update_done_flag_reg, 4'h0} :
        RST_ZERO;

    // read data holds until the next read
    always_ff @(posedge clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rdata_o <= RST_ZERO;
        end else if (req_i.rd) begin
            rdata_o <= rd_mux;
        end
    end

    // second divider and update phase; set mode parks it and drops pending
    always_ff @(posedge clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            phase_reg   <= ST_RUN;
            sec_cnt_reg <= '0;
            upd_cnt_reg <= '0;
        end else if (set_mode) begin
            phase_reg   <= ST_RUN;
            sec_cnt_reg <= '0;
            upd_cnt_reg <= '0;
        end else begin
            sec_cnt_reg <= (sec_cnt_reg == 32'(SEC_CYC - 1)) ? '0 : sec_cnt_reg + 32'd1;
            upd_cnt_reg <= (phase_reg == ST_UPD) ? upd_cnt_reg + 32'd1 : '0;
            case (phase_reg)
                ST_RUN:  if (sec_cnt_reg == 32'(SEC_CYC - LEAD_CYC - 1)) begin
                    phase_reg <= ST_PEND;
                end
                ST_PEND: if (inc_pulse) begin
                    phase_reg <= ST_UPD;
                end
                ST_UPD:  if (upd_end) begin
                    phase_reg <= ST_RUN;
                end
                default: phase_reg <= ST_RUN;
            endcase
        end
    end

    // flags: a new event wins over the clear of a flag read
    always_ff @(posedge clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            alarm_flag_reg       <= 1'b0;
            update_done_flag_reg <= 1'b0;
        end else begin
            // an event in the read cycle survives the clear, so no event is lost
            alarm_flag_reg <= (alarm_flag_reg & ~flg_rd) | (upd_end & all_match);
            update_done_flag_reg <= (update_done_flag_reg & ~flg_rd) | upd_end;
        end
    end

    // counters and settings; a software write overrides the same-cycle increment
    always_ff @(posedge clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sec_reg  <= RST_ZERO[6:0];
            asec_reg <= RST_ZERO[6:0];
            min_reg  <= RST_ZERO[6:0];
            amin_reg <= RST_ZERO[6:0];
            hr_reg   <= RST_ZERO;
            ahr_reg  <= RST_ZERO;
            wday_reg <= RST_ONE[2:0];
            mday_reg <= RST_ONE[5:0];
            mon_reg  <= RST_ONE[4:0];
            year_reg <= RST_ZERO;
            ctrl_reg <= RST_CTRL;
        end else begin
            if (inc_pulse && !set_mode) begin
                sec_reg  <= sec_nx[6:0];
                min_reg  <= min_nx[6:0];
                hr_reg   <= hr_nx;
                wday_reg <= wday_nx;
                mday_reg <= mday_nx[5:0];
                mon_reg  <= mon_nx[4:0];
                year_reg <= year_nx;
            end
            if (req_i.wr) begin
                case (req_i.addr)
                    ADDR_SEC:  sec_reg  <= req_i.wdata[6:0];
                    ADDR_ASEC: asec_reg <= req_i.wdata[6:0];
                    ADDR_MIN:  min_reg  <= req_i.wdata[6:0];
                    ADDR_AMIN: amin_reg <= req_i.wdata[6:0];
                    ADDR_HR:   hr_reg   <= req_i.wdata & MSK_HR;
                    ADDR_AHR:  ahr_reg  <= req_i.wdata & MSK_HR;
                    ADDR_WDAY: wday_reg <= req_i.wdata[2:0];
                    ADDR_MDAY: mday_reg <= req_i.wdata[5:0];
                    ADDR_MON:  mon_reg  <= req_i.wdata[4:0];
                    ADDR_YEAR: year_reg <= req_i.wdata;
                    ADDR_CTRL: ctrl_reg <= req_i.wdata & MSK_CTRL;
                    default:   ;                          // status, flags: read only
                endcase
            end
        end
    end

    // checks
    sequence s_upd_done;
        upd_end ##1 (phase_reg == ST_RUN);
    endsequence

    property p_irq_eq;
        @(posedge clk_i) disable iff (!rst_sync_n)
        irq_o == ((alarm_flag_reg && ctrl_reg[B_ALM_IRQ_EN])
                  || (update_done_flag_reg && ctrl_reg[B_UPD_IRQ_EN]));
    endproperty
    a_irq_eq: assert property (p_irq_eq) else $error("irq mismatch");

    property p_set_abort;
        @(posedge clk_i) disable iff (!rst_sync_n)
        set_mode |=> !update_pending_flag;
    endproperty
    a_set_abort: assert property (p_set_abort) else $error("update ran in set mode");

    property p_lead;
        @(posedge clk_i) disable iff (!rst_sync_n)
        $rose(update_pending_flag) |-> !inc_pulse [*8];
    endproperty
    a_lead: assert property (p_lead) else $error("increment without lead");

    property p_alarm_set;
        @(posedge clk_i) disable iff (!rst_sync_n)
        (upd_end && all_match) |-> s_upd_done ##0 alarm_flag_reg;
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm missed");

    property p_alarm_quiet;
        @(posedge clk_i) disable iff (!rst_sync_n)
        (upd_end && !all_match && !alarm_flag_reg) |=> !alarm_flag_reg;
    endproperty
    a_alarm_quiet: assert property (p_alarm_quiet) else $error("false alarm");

    property p_rd_clear;
        @(posedge clk_i) disable iff (!rst_sync_n)
        (flg_rd && !upd_end) |=> (!alarm_flag_reg && !update_done_flag_reg && !irq_o);
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("flags not cleared");

    property p_rd_hold;
        @(posedge clk_i) disable iff (!rst_sync_n)
        (flg_rd && upd_end) |=> update_done_flag_reg;
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("event lost on read");

    property p_mon_top;
        @(posedge clk_i) disable iff (!rst_sync_n)
        (req_i.rd && req_i.addr == ADDR_MON) |=> !rdata_o[B_TOP];
    endproperty
    a_mon_top: assert property (p_mon_top) else $error("month bit 7 set");

    property p_stat_rd;
        @(posedge clk_i) disable iff (!rst_sync_n)
        (req_i.rd && req_i.addr == ADDR_STAT) |=>
            (rdata_o == (RST_STAT | {$past(update_pending_flag), 7'h00}));
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("status read wrong");

    property p_inc_run;
        @(posedge clk_i) disable iff (!rst_sync_n)
        inc_pulse && !set_mode |=> (phase_reg == ST_UPD)
            ##1 (update_pending_flag || $past(set_mode));
    endproperty
    a_inc_run: assert property (p_inc_run) else $error("update window broken");

endmodule // rtc_time_calendar_regs

/* File: verif/rtc_time_calendar_regs_tb.sv */
`timescale 1ns/10ps
module rtc_time_calendar_regs_tb;
    import rtc_pkg::*;
    // short second keeps the run small; lead shortened too, update window left at UPD_CYC
    localparam int SIM_SEC  = 1700;
    localparam int SIM_LEAD = 20;
    localparam int LIMIT    = 20000;

    logic        clk_i;
    logic        rst_n_i;
    reg_req_t    req;
    logic [7:0]  rdata;
    logic        irq;
    logic [7:0]  rv;
    logic [7:0]  addr_v;
    logic [7:0]  data_v;
    logic [15:0] lfsr;
    logic [7:0]  ld [10];
    logic [7:0]  ex [10];
    int          mismatches;
    int          comparisons;
    int          cycles;

    rtc_time_calendar_regs #(
        .SEC_CYC  (SIM_SEC),
        .LEAD_CYC (SIM_LEAD)
    ) dut_u (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .req_i   (req),
        .rdata_o (rdata),
        .irq_o   (irq)
    );

    // 50 MHz clock
    always #10 clk_i = ~clk_i;

    // hang guard: cut the run short if a wait never ends
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches = mismatches + 1;
            $display("Error at %0t: run took too long", $time);
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // compare a register byte
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // compare a single flag
    task automatic chk1(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // strobes are lowered a full cycle before the next request to avoid same-step rewrites
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk_i);
        req.wr = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk_i);
        req.rd = 1'b0;
        d = rdata;
        @(negedge clk_i);
    endtask

    function automatic logic [7:0] rst_val(input logic [7:0] a);
        case (a)
            ADDR_WDAY, ADDR_MDAY, ADDR_MON: return RST_ONE;
            ADDR_STAT: return RST_STAT;
            ADDR_CTRL: return RST_CTRL;
            default: return RST_ZERO;
        endcase
    endfunction

    // bits that a write can change; reserved bits stay zero
    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            ADDR_SEC, ADDR_ASEC, ADDR_MIN, ADDR_AMIN: return 8'h7f;
            ADDR_HR, ADDR_AHR: return 8'hbf;
            ADDR_WDAY: return 8'h07;
            ADDR_MDAY: return 8'h3f;
            ADDR_MON: return 8'h1f;
            ADDR_YEAR: return 8'hff;
            ADDR_CTRL: return 8'hb6;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // poll the pending bit through one whole update; polls are two cycles apart
    task automatic wait_update();
        int n;
        int hi;
        n = 0;
        hi = 0;
        rv = 8'h00;
        while (rv[7] !== 1'b1 && n < SIM_SEC) begin
            reg_read(ADDR_STAT, rv);
            n++;
        end
        chk1(rv[7], 1'b1, "pending rose");
        while (rv[7] !== 1'b0 && hi < SIM_SEC) begin
            reg_read(ADDR_STAT, rv);
            hi++;
        end
        chk1(rv[7], 1'b0, "pending fell");
        n = (SIM_LEAD + UPD_CYC) / 2;
        chk1(hi >= n - 2 && hi <= n + 2, 1'b1, "pending width");
    endtask

    // load ld[] in set mode, run with control c, then expect ex[]
    task automatic run_second(input logic [7:0] c);
        reg_write(ADDR_CTRL, c | 8'h80);
        for (int i = 0; i < 10; i++) reg_write(8'(16 + i), ld[i]);
        reg_write(ADDR_CTRL, c);
        wait_update();
        for (int i = 0; i < 10; i++) begin
            reg_read(8'(16 + i), rv);
            chk8(rv, ex[i], "counter after update");
        end
    endtask

    initial begin
        clk_i = 1'b0;
        rst_n_i = 1'b0;
        req = '0;
        mismatches = 0;
        comparisons = 0;
        cycles = 0;
        lfsr = 16'h1f10;
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_i);
        // reset values, the flag byte and unmapped offsets
        chk1(irq, 1'b0, "request after reset");
        for (int a = 16; a <= 31; a++) begin
            reg_read(8'(a), rv);
            chk8(rv, rst_val(8'(a)), "reset value");
        end
        $display("test reset done");
        // all ones into every register but the flag byte while frozen; status must ignore it
        reg_write(ADDR_CTRL, 8'h80);
        for (int a = 16; a <= 27; a++) begin
            reg_write(8'(a), 8'hff);
            reg_read(8'(a), rv);
            data_v = (8'(a) == ADDR_STAT) ? RST_STAT : wmask(8'(a));
            chk8(rv, data_v, "reserved bits");
        end
        // random fills of the counters and alarms
        repeat (24) begin
            lfsr = lfsr_next(lfsr);
            addr_v = 8'(16 + (lfsr[3:0] % 4'd10));
            data_v = lfsr[15:8];
            reg_write(addr_v, data_v);
            reg_read(addr_v, rv);
            chk8(rv, data_v & wmask(addr_v), "random write");
        end
        // set mode holds the count across more than a second
        reg_write(ADDR_SEC, 8'h15);
        repeat (SIM_SEC + 100) @(negedge clk_i);
        reg_read(ADDR_SEC, rv);
        chk8(rv, 8'h15, "frozen seconds");
        reg_read(ADDR_STAT, rv);
        chk8(rv, RST_STAT, "no pending when frozen");
        $display("test set mode done");
        // bcd 24 hour: every counter wraps at year end, update interrupt only
        ld = '{8'h59, 8'h30, 8'h59, 8'h00, 8'h23, 8'h05, 8'h07, 8'h31, 8'h12, 8'h99};
        ex = '{8'h00, 8'h30, 8'h00, 8'h00, 8'h00, 8'h05, 8'h01, 8'h01, 8'h01, 8'h00};
        run_second(8'h12);
        chk1(irq, 1'b1, "update request");
        reg_read(ADDR_FLAG, rv);
        chk8(rv, 8'h90, "flags update only");
        chk1(irq, 1'b0, "request cleared");
        reg_read(ADDR_FLAG, rv);
        chk8(rv, 8'h00, "flags after clear");
        $display("test bcd rollover done");
        // bcd 12 hour: am 11:59:59 turns pm 12 with no new day; alarm set for pm 12
        ld = '{8'h59, 8'h00, 8'h59, 8'h00, 8'h11, 8'h92, 8'h05, 8'h30, 8'h04, 8'h23};
        ex = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h92, 8'h92, 8'h05, 8'h30, 8'h04, 8'h23};
        run_second(8'h20);
        chk1(irq, 1'b1, "pm alarm request");
        reg_read(ADDR_FLAG, rv);
        chk8(rv, 8'hb0, "flags pm alarm");
        $display("test bcd 12 hour done");
        // binary 12 hour: pm 11:59:59 to am 12 on leap day, alarm matches
        ld = '{8'h3b, 8'h00, 8'h3b, 8'h00, 8'h8b, 8'h0c, 8'h03, 8'h1c, 8'h02, 8'h04};
        ex = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0c, 8'h0c, 8'h04, 8'h1d, 8'h02, 8'h04};
        run_second(8'h24);
        chk1(irq, 1'b1, "alarm request");
        reg_read(ADDR_FLAG, rv);
        chk8(rv, 8'hb0, "flags alarm and update");
        chk1(irq, 1'b0, "request cleared");
        // next second: update flag alone is masked off
        wait_update();
        chk1(irq, 1'b0, "masked update");
        reg_read(ADDR_FLAG, rv);
        chk8(rv, 8'h10, "update flag masked");
        reg_read(ADDR_SEC, rv);
        chk8(rv, 8'h01, "one more second");
        $display("test alarm done");
        give_verdict();
    end
endmodule // rtc_time_calendar_regs_tb
